// ==== rtl/sfpp_alu.v ====
// Combinational fixed-point arithmetic unit with saturating 16/32-bit primitives.
`timescale 1ns/1ps
`include "sfpp_regs.vh"

module sfpp_alu (
  input  wire [3:0]  op,   // Operation select.
  input  wire [15:0] a16,  // First 16-bit operand.
  input  wire [15:0] b16,  // Second 16-bit operand.
  input  wire [31:0] a32,  // First 32-bit operand.
  input  wire [31:0] b32,  // Second 32-bit operand.
  input  wire [5:0]  sh,   // Signed shift count.
  output reg  [15:0] r16,  // 16-bit result.
  output reg  [31:0] r32   // 32-bit result.
);

  // ************************************************************
  // Shared datapath terms
  // ************************************************************
  // Seventeen-bit sums keep the carry so overflow is visible.
  wire [16:0] sum16 = {a16[15], a16} + {b16[15], b16};
  wire [16:0] dif16 = {a16[15], a16} - {b16[15], b16};
  // Thirty-three-bit sums do the same for the long forms.
  wire [32:0] sum32 = {a32[31], a32} + {b32[31], b32};
  wire [32:0] dif32 = {a32[31], a32} - {b32[31], b32};
  // Full signed product of the short operands.
  wire [31:0] prod  = $signed(a16) * $signed(b16);
  wire [31:0] prodr = prod + `SFPP_ROUND16;
  // The one product that does not fit a fraction.
  wire        both_min = (a16 == `SFPP_MIN16) && (b16 == `SFPP_MIN16);
  // A negative count turns the shift around.
  wire [5:0]  mag = sh[5] ? (6'h00 - sh) : sh;
  // Arithmetic right shifts are formed on their own nets. Inside a
  // conditional with an unsigned branch they would turn unsigned and
  // shift in zeros instead of copies of the sign bit.
  wire [15:0] asr16 = $signed(a16) >>> mag;
  wire [31:0] asr32 = $signed(a32) >>> mag;

  // Quotient by restoring division, one bit per step.
  reg [15:0] quot;
  reg [31:0] rem;
  integer    k;
  always @* begin
    quot = 16'h0000;
    rem  = {16'h0000, a16};
    for (k = 0; k < 15; k = k + 1) begin
      quot = {quot[14:0], 1'b0};
      rem  = {rem[30:0], 1'b0};
      if (rem >= {16'h0000, b16}) begin
        rem  = rem - {16'h0000, b16};
        quot = quot + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Result select
  // ************************************************************
  // One case picks the primitive; unused halves read zero.
  always @* begin
    r16 = 16'h0000;
    r32 = 32'h00000000;
    case (op)
      `SFPP_OP_ADD: begin
        if (sum16[16] != sum16[15])
          r16 = sum16[16] ? `SFPP_MIN16 : `SFPP_MAX16;
        else
          r16 = sum16[15:0];
      end
      `SFPP_OP_SUB: begin
        if (dif16[16] != dif16[15])
          r16 = dif16[16] ? `SFPP_MIN16 : `SFPP_MAX16;
        else
          r16 = dif16[15:0];
      end
      `SFPP_OP_MULT: begin
        r16 = both_min ? `SFPP_MAX16 : prod[30:15];
      end
      `SFPP_OP_MULTR: begin
        r16 = both_min ? `SFPP_MAX16 : prodr[30:15];
      end
      `SFPP_OP_ABS: begin
        if (a16 == `SFPP_MIN16)
          r16 = `SFPP_MAX16;
        else
          r16 = a16[15] ? (16'h0000 - a16) : a16;
      end
      `SFPP_OP_DIV: begin
        r16 = quot;
      end
      `SFPP_OP_LMULT: begin
        r32 = {prod[30:0], 1'b0};
      end
      `SFPP_OP_LADD: begin
        if (sum32[32] != sum32[31])
          r32 = sum32[32] ? `SFPP_MIN32 : `SFPP_MAX32;
        else
          r32 = sum32[31:0];
      end
      `SFPP_OP_LSUB: begin
        if (dif32[32] != dif32[31])
          r32 = dif32[32] ? `SFPP_MIN32 : `SFPP_MAX32;
        else
          r32 = dif32[31:0];
      end
      `SFPP_OP_SHL16: begin
        r16 = sh[5] ? asr16 : (a16 << mag);
      end
      `SFPP_OP_SHR16: begin
        r16 = sh[5] ? (a16 << mag) : asr16;
      end
      `SFPP_OP_SHL32: begin
        r32 = sh[5] ? asr32 : (a32 << mag);
      end
      `SFPP_OP_SHR32: begin
        r32 = sh[5] ? (a32 << mag) : asr32;
      end
      `SFPP_OP_DEPOSIT: begin
        r32 = {{16{a16[15]}}, a16};
      end
      `SFPP_OP_EXTRACT: begin
        r16 = a32[15:0];
      end
      default: begin
        r16 = 16'h0000;
        r32 = 32'h00000000;
      end
    endcase
  end

endmodule // sfpp_alu

// ==== rtl/sfpp_regs.vh ====
// Constants for the speech pre-processing core: opcodes, saturation limits and filter figures.
`ifndef SFPP_REGS_VH
`define SFPP_REGS_VH

// ************************************************************
// Arithmetic opcodes
// ************************************************************
`define SFPP_OP_ADD     4'h0
`define SFPP_OP_SUB     4'h1
`define SFPP_OP_MULT    4'h2
`define SFPP_OP_MULTR   4'h3
`define SFPP_OP_ABS     4'h4
`define SFPP_OP_DIV     4'h5
`define SFPP_OP_LMULT   4'h6
`define SFPP_OP_LADD    4'h7
`define SFPP_OP_LSUB    4'h8
`define SFPP_OP_SHL16   4'h9
`define SFPP_OP_SHR16   4'hA
`define SFPP_OP_SHL32   4'hB
`define SFPP_OP_SHR32   4'hC
`define SFPP_OP_DEPOSIT 4'hD
`define SFPP_OP_EXTRACT 4'hE

// ************************************************************
// Saturation limits
// ************************************************************
`define SFPP_MAX16      16'h7FFF
`define SFPP_MIN16      16'h8000
`define SFPP_MAX32      32'h7FFFFFFF
`define SFPP_MIN32      32'h80000000

// ************************************************************
// Filter figures
// ************************************************************
`define SFPP_ROUND16    32'h00004000
`define SFPP_HP_COEF    16'h7FDF
`define SFPP_DS_RIGHT   3
`define SFPP_DS_LEFT    2
`define SFPP_SPLIT      15
`define SFPP_SAMPLE_MSK 16'hFFF8
`define SFPP_FRAME_LEN  8'h9F
`define SFPP_SUBSEG_LEN 6'h27

`endif

// ==== rtl/sfpp_top.v ====
// Speech pre-processing core: downscaling, offset filter and shared arithmetic unit.
// Operation
// - 16-bit add saturates both ways
// - 16-bit subtract saturates both ways
// - Scaled multiply, min times min gives max
// - Rounding multiply adds half before shift
// - Absolute value, minimum maps to max
// - Fractional divide, equal operands give max
// - Long multiply is product shifted left
// - 32-bit add saturates both ways
// - 32-bit subtract saturates both ways
// - Short to long sign-extends
// - Long to short keeps low half
// - Constants sign-extended in long operations
// - Left shift zero fills, negative reverses
// - Right shift arithmetic, negative reverses
// - Only valid sample bits affect results
// - Frames of 160, subsegments of 40
// - Downscale: right three, left two
// - Saturated first difference, keep previous
// - Recursive state update with coefficient
// - Output is rounded state shifted
// - Filter memories persist, reset to zero
`timescale 1ns/1ps
`include "sfpp_regs.vh"

module sfpp_top (
  input  wire        clk,              // System clock, 20 MHz.
  input  wire        arst_n,           // Asynchronous reset, active low.
  input  wire        in_valid,         // Input sample present.
  input  wire [15:0] in_sample,        // Left-justified input sample.
  input  wire        in_frame_start,   // Marks the first sample of a frame.
  output reg         in_ready_ff,      // Core can take a sample.
  output reg         out_valid_ff,     // Filtered sample strobe.
  output reg  [15:0] out_sample_ff,    // Filtered sample.
  output reg         out_frame_ff,     // Output is first of a frame.
  output reg         out_subseg_ff,    // Output is first of a subsegment.
  output reg  [1:0]  out_segnum_ff,    // Subsegment number of the output.
  input  wire        op_valid,         // Arithmetic request present.
  input  wire [3:0]  op_code,          // Arithmetic opcode.
  input  wire [15:0] op_a16,           // First short operand.
  input  wire [15:0] op_b16,           // Second short operand.
  input  wire [31:0] op_a32,           // First long operand.
  input  wire [31:0] op_b32,           // Second long operand.
  input  wire [5:0]  op_shift,         // Signed shift count.
  output reg         op_ready_ff,      // Core can take a request.
  output reg         op_done_ff,       // Result strobe.
  output reg  [15:0] op_r16_ff,        // Short result.
  output reg  [31:0] op_r32_ff         // Long result.
);

  // ************************************************************
  // Sequencer states
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'd0;  // Waiting for a sample or a request.
  localparam [2:0] ST_DIFF = 3'd1;  // First difference.
  localparam [2:0] ST_LSP  = 3'd2;  // Low part of the state.
  localparam [2:0] ST_MR   = 3'd3;  // Rounded low product.
  localparam [2:0] ST_S2   = 3'd4;  // Recursive accumulator.
  localparam [2:0] ST_LM   = 3'd5;  // Long high product.
  localparam [2:0] ST_Z2   = 3'd6;  // New filter state.
  localparam [2:0] ST_OUT  = 3'd7;  // Rounded output.

  // ************************************************************
  // Storage
  // ************************************************************
  reg  [2:0]  state_ff;              // Sequencer state.
  reg  [2:0]  nxt_state;             // Next sequencer state.
  reg  [15:0] down_ff;               // Downscaled current sample.
  reg  [15:0] prev_sample_state_ff;  // Previous downscaled sample.
  reg  [31:0] hp_filter_state_ff;    // Recursive filter state.
  reg  [31:0] recursive_accum_ff;    // Recursive accumulator.
  reg  [15:0] first_difference_ff;   // Saturated first difference.
  reg  [15:0] low_part_ff;           // Low part of the state.
  reg  [15:0] temp_ff;               // Rounded product of low part.
  reg  [31:0] long_prod_ff;          // Long product of high part.
  reg  [7:0]  index_ff;              // Sample position within frame.
  reg  [5:0]  seg_pos_ff;            // Position within subsegment.
  reg  [1:0]  seg_num_ff;            // Subsegment number.
  reg         tag_frame_ff;          // Current sample opens a frame.
  reg         tag_subseg_ff;         // Current sample opens a subsegment.
  reg  [1:0]  tag_segnum_ff;         // Subsegment of the current sample.

  // ************************************************************
  // Arithmetic unit wiring
  // ************************************************************
  reg  [3:0]  alu_op;                // Opcode fed to the unit.
  reg  [15:0] alu_a16;               // Short operand A.
  reg  [15:0] alu_b16;               // Short operand B.
  reg  [31:0] alu_a32;               // Long operand A.
  reg  [31:0] alu_b32;               // Long operand B.
  reg  [5:0]  alu_sh;                // Shift count.
  wire [15:0] alu_r16;               // Short result.
  wire [31:0] alu_r32;               // Long result.

  // High part of the state is the state shifted down, truncated to 16 bits.
  wire [31:0] state_shr = $signed(hp_filter_state_ff) >>> `SFPP_SPLIT;
  wire [15:0] high_part = state_shr[15:0];
  wire [31:0] high_long = {{16{high_part[15]}}, high_part};
  wire [31:0] high_back = high_long << `SFPP_SPLIT;
  wire [31:0] diff_long = {{16{first_difference_ff[15]}}, first_difference_ff};
  wire [31:0] diff_up   = diff_long << `SFPP_SPLIT;
  wire [31:0] temp_long = {{16{temp_ff[15]}}, temp_ff};
  wire [31:0] half_prod = $signed(long_prod_ff) >>> 1;
  // Output word before truncation.
  wire [31:0] out_shr   = $signed(alu_r32) >>> `SFPP_SPLIT;

  wire [15:0] valid_bits = in_sample & `SFPP_SAMPLE_MSK;
  wire [15:0] down_right = $signed(valid_bits) >>> `SFPP_DS_RIGHT;
  wire [15:0] down_calc  = down_right << `SFPP_DS_LEFT;

  // Handshakes; a sample wins over a request in the same cycle, since
  // the source is paced by frames and a request can always wait.
  wire take_sample = in_valid & in_ready_ff;
  wire take_op     = op_valid & op_ready_ff & ~in_valid;

  sfpp_alu u_alu (
    .op  (alu_op),
    .a16 (alu_a16),
    .b16 (alu_b16),
    .a32 (alu_a32),
    .b32 (alu_b32),
    .sh  (alu_sh),
    .r16 (alu_r16),
    .r32 (alu_r32)
  );

  // ************************************************************
  // Operand steering
  // ************************************************************
  // Each filter step borrows the unit for one cycle; in idle the unit
  // serves the request port, so the filter costs no extra arithmetic.
  always @* begin
    alu_op  = op_code;
    alu_a16 = op_a16;
    alu_b16 = op_b16;
    alu_a32 = op_a32;
    alu_b32 = op_b32;
    alu_sh  = op_shift;
    case (state_ff)
      ST_DIFF: begin
        alu_op  = `SFPP_OP_SUB;
        alu_a16 = down_ff;
        alu_b16 = prev_sample_state_ff;
      end
      ST_LSP: begin
        alu_op  = `SFPP_OP_LSUB;
        alu_a32 = hp_filter_state_ff;
        alu_b32 = high_back;
      end
      ST_MR: begin
        alu_op  = `SFPP_OP_MULTR;
        alu_a16 = low_part_ff;
        alu_b16 = `SFPP_HP_COEF;
      end
      ST_S2: begin
        alu_op  = `SFPP_OP_LADD;
        alu_a32 = diff_up;
        alu_b32 = temp_long;
      end
      ST_LM: begin
        alu_op  = `SFPP_OP_LMULT;
        alu_a16 = high_part;
        alu_b16 = `SFPP_HP_COEF;
      end
      ST_Z2: begin
        alu_op  = `SFPP_OP_LADD;
        alu_a32 = half_prod;
        alu_b32 = recursive_accum_ff;
      end
      ST_OUT: begin
        alu_op  = `SFPP_OP_LADD;
        alu_a32 = hp_filter_state_ff;
        alu_b32 = `SFPP_ROUND16;
      end
      default: begin
        alu_op  = op_code;
      end
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  // The steps run in fixed order; only idle waits on the ports.
  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = take_sample ? ST_DIFF : ST_IDLE;
      ST_DIFF: nxt_state = ST_LSP;
      ST_LSP:  nxt_state = ST_MR;
      ST_MR:   nxt_state = ST_S2;
      ST_S2:   nxt_state = ST_LM;
      ST_LM:   nxt_state = ST_Z2;
      ST_Z2:   nxt_state = ST_OUT;
      ST_OUT:  nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ************************************************************
  // Sequencer and filter memories
  // ************************************************************
  // The memories are never cleared between frames; only reset clears
  // them, so the filter carries its history across frame borders.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff             <= ST_IDLE;
      in_ready_ff          <= 1'b0;
      op_ready_ff          <= 1'b0;
      down_ff              <= 16'h0000;
      prev_sample_state_ff <= 16'h0000;
      hp_filter_state_ff   <= 32'h00000000;
      recursive_accum_ff   <= 32'h00000000;
      first_difference_ff  <= 16'h0000;
      low_part_ff          <= 16'h0000;
      temp_ff              <= 16'h0000;
      long_prod_ff         <= 32'h00000000;
    end else begin
      state_ff    <= nxt_state;
      // Ready is dropped as soon as a sample is taken.
      in_ready_ff <= (nxt_state == ST_IDLE);
      op_ready_ff <= (nxt_state == ST_IDLE);
      if (take_sample) begin
        down_ff <= down_calc;
      end
      case (state_ff)
        ST_DIFF: begin
          first_difference_ff  <= alu_r16;
          prev_sample_state_ff <= down_ff;
        end
        ST_LSP: begin
          low_part_ff <= alu_r32[15:0];
        end
        ST_MR: begin
          temp_ff <= alu_r16;
        end
        ST_S2: begin
          recursive_accum_ff <= alu_r32;
        end
        ST_LM: begin
          long_prod_ff <= alu_r32;
        end
        ST_Z2: begin
          hp_filter_state_ff <= alu_r32;
        end
        default: begin
          down_ff <= take_sample ? down_calc : down_ff;
        end
      endcase
    end
  end

  // ************************************************************
  // Frame position
  // ************************************************************
  // A frame-start marker forces the count back to the first sample,
  // which resynchronises a source that slipped; without it the count
  // simply wraps after the last sample of a frame.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      index_ff      <= 8'h00;
      seg_pos_ff    <= 6'h00;
      seg_num_ff    <= 2'h0;
      tag_frame_ff  <= 1'b0;
      tag_subseg_ff <= 1'b0;
      tag_segnum_ff <= 2'h0;
    end else if (take_sample) begin
      if (in_frame_start) begin
        tag_frame_ff  <= 1'b1;
        tag_subseg_ff <= 1'b1;
        tag_segnum_ff <= 2'h0;
        index_ff      <= 8'h01;
        seg_pos_ff    <= 6'h01;
        seg_num_ff    <= 2'h0;
      end else begin
        tag_frame_ff  <= (index_ff == 8'h00);
        tag_subseg_ff <= (seg_pos_ff == 6'h00);
        tag_segnum_ff <= seg_num_ff;
        index_ff      <= (index_ff == `SFPP_FRAME_LEN) ? 8'h00 : index_ff + 8'h01;
        if (seg_pos_ff == `SFPP_SUBSEG_LEN) begin
          seg_pos_ff <= 6'h00;
          seg_num_ff <= (index_ff == `SFPP_FRAME_LEN) ? 2'h0 : seg_num_ff + 2'h1;
        end else begin
          seg_pos_ff <= seg_pos_ff + 6'h01;
        end
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // The sample stream has no stall: the sink must take every strobe.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_ff  <= 1'b0;
      out_sample_ff <= 16'h0000;
      out_frame_ff  <= 1'b0;
      out_subseg_ff <= 1'b0;
      out_segnum_ff <= 2'h0;
      op_done_ff    <= 1'b0;
      op_r16_ff     <= 16'h0000;
      op_r32_ff     <= 32'h00000000;
    end else begin
      out_valid_ff <= (state_ff == ST_OUT);
      op_done_ff   <= (state_ff == ST_IDLE) & take_op;
      if (state_ff == ST_OUT) begin
        out_sample_ff <= out_shr[15:0];
        out_frame_ff  <= tag_frame_ff;
        out_subseg_ff <= tag_subseg_ff;
        out_segnum_ff <= tag_segnum_ff;
      end
      if ((state_ff == ST_IDLE) & take_op) begin
        op_r16_ff <= alu_r16;
        op_r32_ff <= alu_r32;
      end
    end
  end

endmodule // sfpp_top

// ==== tb/sfpp_assertions.sv ====
// Checker of port timing and saturation for the pre-processing core.
`timescale 1ns/1ps
module sfpp_assertions (
  input wire        clk,
  input wire        arst_n,
  input wire        in_valid,
  input wire        in_ready_ff,
  input wire        out_valid_ff,
  input wire [15:0] out_sample_ff,
  input wire        out_frame_ff,
  input wire        out_subseg_ff,
  input wire [1:0]  out_segnum_ff,
  input wire        op_valid,
  input wire [3:0]  op_code,
  input wire [15:0] op_a16,
  input wire [15:0] op_b16,
  input wire        op_ready_ff,
  input wire        op_done_ff,
  input wire [15:0] op_r16_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  out_latency_a: assert property (in_valid && in_ready_ff |-> ##8 out_valid_ff)
    else $error("sample result not eight cycles after take");
  ready_gap_a: assert property (in_valid && in_ready_ff |=> !in_ready_ff [*7])
    else $error("sample ready rose too early");
  op_latency_a: assert property (op_valid && op_ready_ff && !in_valid |=> op_done_ff)
    else $error("arithmetic result late");
  ready_equal_a: assert property (op_ready_ff == in_ready_ff)
    else $error("the two ready flags differ");
  out_pulse_a: assert property (out_valid_ff |=> !out_valid_ff)
    else $error("sample strobe longer than one cycle");
  out_hold_a: assert property ($changed(out_sample_ff) |-> out_valid_ff)
    else $error("output sample changed without strobe");
  frame_tags_a: assert property (out_valid_ff && out_frame_ff |->
    out_subseg_ff && out_segnum_ff == 2'h0) else $error("frame start tags wrong");
  add_sat_a: assert property (op_valid && op_ready_ff && !in_valid && op_code == 4'h0 &&
    !op_a16[15] && !op_b16[15] && ({1'b0, op_a16} + {1'b0, op_b16}) > 17'h07FFF
    |=> op_r16_ff == 16'h7FFF) else $error("add did not clamp high");
  abs_min_a: assert property (op_valid && op_ready_ff && !in_valid && op_code == 4'h4 &&
    op_a16 == 16'h8000 |=> op_r16_ff == 16'h7FFF) else $error("abs of minimum wrong");
endmodule // sfpp_assertions
bind sfpp_top sfpp_assertions u_chk (.clk(clk), .arst_n(arst_n), .in_valid(in_valid),
  .in_ready_ff(in_ready_ff), .out_valid_ff(out_valid_ff), .out_sample_ff(out_sample_ff),
  .out_frame_ff(out_frame_ff), .out_subseg_ff(out_subseg_ff), .out_segnum_ff(out_segnum_ff),
  .op_valid(op_valid), .op_code(op_code), .op_a16(op_a16), .op_b16(op_b16),
  .op_ready_ff(op_ready_ff), .op_done_ff(op_done_ff), .op_r16_ff(op_r16_ff));

// ==== tb/sfpp_src.sv ====
// Sample source model feeding left-justified samples over the handshake.
`timescale 1ns/1ps
module sfpp_src (
  input  wire         clk,
  input  wire         in_ready_ff,
  output logic        in_valid,
  output logic [15:0] in_sample,
  output logic        in_frame_start
);
  initial begin
    in_valid = 1'b0;
    in_sample = 16'h0000;
    in_frame_start = 1'b0;
  end
  task send(input logic [15:0] s, input logic fs);
    begin
      in_valid = 1'b1;
      in_sample = s;
      in_frame_start = fs;
      while (in_ready_ff !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      @(posedge clk);
      #2;
    end
  endtask
  // Released data shows the inverse so a stale value never looks valid.
  task stop;
    begin
      in_valid = 1'b0;
      in_frame_start = 1'b0;
      in_sample = ~in_sample;
    end
  endtask
endmodule // sfpp_src

// ==== tb/test_speech_fixed_point_preproc.sv ====
// Self-checking bench for the speech pre-processing core.
`timescale 1ns/1ps
module test_speech_fixed_point_preproc;
  logic               clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0;
  logic        [15:0] op_a16 = 16'h0000, op_b16 = 16'h0000, x, a, b;
  logic        [31:0] op_a32 = 32'h00000000, op_b32 = 32'h00000000;
  logic        [3:0]  op_code = 4'h0;
  logic        [5:0]  op_shift = 6'h00;
  wire                in_valid, in_frame_start, in_ready_ff, out_valid_ff, op_done_ff;
  wire                out_frame_ff, out_subseg_ff, op_ready_ff;
  wire         [1:0]  out_segnum_ff;
  wire         [15:0] in_sample, out_sample_ff, op_r16_ff;
  wire         [31:0] op_r32_ff;
  int                 errors = 0, n_tests = 0, pos_ref = 0;
  logic signed [31:0] z2_ref = 32'h00000000;
  logic signed [15:0] z1_ref = 16'h0000;
  logic        [19:0] exp_smp[$];
  logic        [47:0] exp_op[$];
  always #25 clk = ~clk;
  sfpp_src u_src (.clk(clk), .in_ready_ff(in_ready_ff), .in_valid(in_valid),
    .in_sample(in_sample), .in_frame_start(in_frame_start));
  sfpp_top u_dut (.clk(clk), .arst_n(arst_n), .in_valid(in_valid), .in_sample(in_sample),
    .in_frame_start(in_frame_start), .in_ready_ff(in_ready_ff), .out_valid_ff(out_valid_ff),
    .out_sample_ff(out_sample_ff), .out_frame_ff(out_frame_ff), .out_subseg_ff(out_subseg_ff),
    .out_segnum_ff(out_segnum_ff), .op_valid(op_valid), .op_code(op_code), .op_a16(op_a16),
    .op_b16(op_b16), .op_a32(op_a32), .op_b32(op_b32), .op_shift(op_shift),
    .op_ready_ff(op_ready_ff), .op_done_ff(op_done_ff), .op_r16_ff(op_r16_ff),
    .op_r32_ff(op_r32_ff));
  function automatic logic [15:0] sat16(input longint v);
    sat16 = (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : v[15:0];
  endfunction
  function automatic logic [31:0] sat32(input longint v);
    sat32 = (v > 64'sd2147483647) ? 32'h7FFFFFFF : (v < -64'sd2147483648) ? 32'h80000000 : v[31:0];
  endfunction
  task check(input logic [47:0] seen, input logic [47:0] exp);
    begin
      n_tests++;
      if (seen !== exp) begin
        errors++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task ref_step(input logic [15:0] s, input logic fs);
    logic signed [15:0] so, s1, msp, lsp, tmp;
    logic signed [31:0] s2, r;
    int p;
    begin
      so = ($signed(s) >>> 3) <<< 2;
      s1 = sat16(longint'(so) - longint'(z1_ref));
      z1_ref = so;
      s2 = s1 * 32768;
      msp = 16'(z2_ref >>> 15);
      lsp = {1'b0, z2_ref[14:0]};
      tmp = 16'((longint'(lsp) * 32735 + 16384) >>> 15);
      s2 = sat32(longint'(s2) + tmp);
      z2_ref = sat32(((longint'(msp) * 32735 * 2) >>> 1) + longint'(s2));
      r = sat32(longint'(z2_ref) + 16384);
      p = fs ? 0 : pos_ref;
      exp_smp.push_back({p == 0, p % 40 == 0, 2'(p / 40), r[30:15]});
      pos_ref = (p == 159) ? 0 : p + 1;
    end
  endtask
  task do_op(input logic [3:0] c, input logic [15:0] a1, b1, input logic [31:0] la, lb,
             input logic [5:0] sh, input logic [31:0] e);
    begin
      exp_op.push_back((c inside {4'h6, 4'h7, 4'h8, 4'hB, 4'hC, 4'hD}) ? {16'h0000, e}
                       : {e[15:0], 32'h00000000});
      op_valid = 1'b1;
      op_code = c;
      op_a16 = a1;
      op_b16 = b1;
      op_a32 = la;
      op_b32 = lb;
      op_shift = sh;
      while (op_ready_ff !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      @(posedge clk);
      #2;
    end
  endtask
  // The oldest note is taken off whenever a result strobe shows.
  always @(posedge clk) begin
    #1;
    if (out_valid_ff === 1'b1)
      check({out_frame_ff, out_subseg_ff, out_segnum_ff, out_sample_ff},
            exp_smp.size() ? exp_smp.pop_front() : 48'hFFFFFFFFFFFF);
    if (op_done_ff === 1'b1)
      check({op_r16_ff, op_r32_ff}, exp_op.size() ? exp_op.pop_front() : 48'hFFFFFFFFFFFF);
  end
  task final_report;
    begin
      errors += exp_smp.size() + exp_op.size();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // The tests need under two thousand cycles; this leaves a fourfold margin.
  initial begin
    #400000;
    errors++;
    final_report;
  end
  initial begin
    void'($urandom(32'h41a93591));
    repeat (2) @(posedge clk);
    #2 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    // random don't-care bits, frame wrap past 160
    for (int k = 0; k < 170; k++) begin
      x = 16'($urandom);
      ref_step(x, k == 0);
      u_src.send(x, k == 0);
    end
    u_src.stop();
    repeat (12) @(posedge clk);
    #2 $display("sample stream test done");
    do_op(4'h0, 16'h7FFF, 16'h0001, 32'h0, 32'h0, 6'h00, 32'h7FFF);
    do_op(4'h1, 16'h8000, 16'h0001, 32'h0, 32'h0, 6'h00, 32'h8000);
    do_op(4'h2, 16'h8000, 16'h8000, 32'h0, 32'h0, 6'h00, 32'h7FFF);
    do_op(4'h2, 16'h4000, 16'h4000, 32'h0, 32'h0, 6'h00, 32'h2000);
    do_op(4'h3, 16'h0001, 16'h4000, 32'h0, 32'h0, 6'h00, 32'h0001);
    do_op(4'h3, 16'h8000, 16'h8000, 32'h0, 32'h0, 6'h00, 32'h7FFF);
    do_op(4'h4, 16'h8000, 16'h0000, 32'h0, 32'h0, 6'h00, 32'h7FFF);
    do_op(4'h5, 16'h1234, 16'h1234, 32'h0, 32'h0, 6'h00, 32'h7FFF);
    do_op(4'h5, 16'h0001, 16'h0002, 32'h0, 32'h0, 6'h00, 32'h4000);
    do_op(4'h6, 16'h0003, 16'hFFFE, 32'h0, 32'h0, 6'h00, 32'hFFFFFFF4);
    do_op(4'h7, 16'h0, 16'h0, 32'h7FFFFFFF, 32'h1, 6'h00, 32'h7FFFFFFF);
    do_op(4'h8, 16'h0, 16'h0, 32'h80000000, 32'h1, 6'h00, 32'h80000000);
    do_op(4'h9, 16'h8004, 16'h0, 32'h0, 32'h0, 6'h3F, 32'hC002);
    do_op(4'hA, 16'h8000, 16'h0, 32'h0, 32'h0, 6'h02, 32'hE000);
    do_op(4'hA, 16'h0001, 16'h0, 32'h0, 32'h0, 6'h3D, 32'h0008);
    do_op(4'hB, 16'h0, 16'h0, 32'h80000010, 32'h0, 6'h3C, 32'hF8000001);
    do_op(4'hC, 16'h0, 16'h0, 32'h00012345, 32'h0, 6'h3C, 32'h00123450);
    do_op(4'hD, 16'h8001, 16'h0, 32'h0, 32'h0, 6'h00, 32'hFFFF8001);
    do_op(4'hE, 16'h0, 16'h0, 32'h12348765, 32'h0, 6'h00, 32'h8765);
    for (int k = 0; k < 20; k++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      do_op(4'h0, a, b, 32'h0, 32'h0, 6'h00, sat16(longint'($signed(a)) + $signed(b)));
    end
    op_valid = 1'b0;
    repeat (4) @(posedge clk);
    #2 $display("arithmetic test done");
    final_report;
  end
endmodule // test_speech_fixed_point_preproc
